//--- hdl/ubmp_pkg.sv
// Constants, field layouts and types of the serial port 0 block.
// Assumes a 32-bit APB with byte addresses and one word per register.

package ubmp_pkg;

  // ****************************************************
  // Register map (index; byte address is four times it)
  // ****************************************************
  localparam logic [5:0] IDX_DATA = 6'h07;  // Shared tx/rx data buffer
  localparam logic [5:0] IDX_MODE = 6'h08;  // Mode register
  localparam logic [5:0] IDX_PHASE = 6'h09; // Baud phase register
  localparam logic [5:0] IDX_CTRL = 6'h0A;  // Serial control register

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [15:0] RST_PHASE = 16'h0000;
  localparam logic [7:0] RST_CTRL = 8'h00;

  // ****************************************************
  // Field layouts
  // ****************************************************
  // Mode register, bit 7 down to bit 0
  typedef struct packed {
    logic pwm_en;     // Combined function onto tx pin
    logic ofs;        // 0: NOR, 1: OR
    logic [2:0] rsvd; // Always zero
    logic irq_en;     // Serial interrupt enable
    logic baud_divisor_select;       // Baud divisor select
    logic framing_check_enable;       // Framing check enable
  } ubmp_mode_t;

  // Serial control register, bit 7 down to bit 0
  typedef struct packed {
    logic sm0;  // Mode bit zero (framing flag when checked)
    logic sm1;  // Mode bit one
    logic sm2;  // Mode bit two
    logic ren;  // Receive enable
    logic tb8;  // Ninth transmit bit
    logic rb8;  // Ninth received bit
    logic ti;   // Transmit flag
    logic ri;   // Receive flag
  } ubmp_ctrl_t;

  // ****************************************************
  // Serial modes and engine states
  // ****************************************************
  typedef enum logic [3:0] {
    SMODE0 = 4'b0001, SMODE1 = 4'b0010,
    SMODE2 = 4'b0100, SMODE3 = 4'b1000
  } ubmp_smode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_ASYNC = 3'b010, ST_SYNC = 3'b100
  } ubmp_state_t;

  // ****************************************************
  // Bit period figures
  // ****************************************************
  localparam int OVERSAMPLE = 16;     // Ticks per async bit
  localparam int PER_M13_FAST = 16;   // Baud clocks, divisor bit 1
  localparam int PER_M13_SLOW = 64;   // Baud clocks, divisor bit 0
  localparam int PER_M2_FAST = 32;    // System clocks, divisor bit 1
  localparam int PER_M2_SLOW = 64;    // System clocks, divisor bit 0
  localparam int PER_M0_SLOW = 12;    // System clocks, sm2 = 0
  localparam int PER_M0_FAST = 4;     // System clocks, sm2 = 1
  localparam logic [3:0] MID_SAMPLE = 4'h7;  // Mid-bit sample tick
  localparam logic [3:0] SYNC_BITS = 4'h8;   // Mode 0 word length
  localparam logic [3:0] M1_BITS = 4'hA;     // Mode 1 frame length
  localparam logic [3:0] M23_BITS = 4'hB;    // Mode 2/3 frame length

  // Mode decode from the two mode bits
  function automatic ubmp_smode_t ubmp_decode(input logic sm0,
                                              input logic sm1);
    case ({sm0, sm1})
      2'b00: return SMODE0;
      2'b01: return SMODE1;
      2'b10: return SMODE2;
      default: return SMODE3;
    endcase
  endfunction

endpackage

//--- hdl/ubmp_tick_gen.sv
// Baud phase accumulator and bit-tick divider for serial port 0.
// Assumes one system clock; tick is one cycle wide.

module ubmp_tick_gen import ubmp_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Configuration
  input wire logic [15:0] phase,
  input wire ubmp_smode_t smode,
  input wire logic baud_divisor_select,
  input wire logic sm2,
  // Tick out
  output logic tick
);

  logic [15:0] acc;       // Phase accumulator
  logic baud_clk;         // Baud clock pulse on carry
  logic [5:0] cnt;        // Divider count
  logic [5:0] div;        // Divide ratio
  logic step;             // Counting event

  // ****************************************************
  // Baud clock from phase accumulator
  // ****************************************************
  // Carry out of the accumulator is the baud clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc <= 16'h0000;
      baud_clk <= 1'b0;
    end
    else
    begin
      {baud_clk, acc} <= {1'b0, acc} + {1'b0, phase};
    end
  end

  // ****************************************************
  // Divider select
  // ****************************************************
  // Async modes tick sixteen times a bit, mode 0 twice a bit
  always_comb
  begin
    div = 6'(PER_M0_SLOW / 2);
    step = 1'b1;
    unique case (smode)
      SMODE1, SMODE3:
      begin
        div = baud_divisor_select ? 6'(PER_M13_FAST / OVERSAMPLE)
                   : 6'(PER_M13_SLOW / OVERSAMPLE);
        step = baud_clk;
      end
      SMODE2:
        div = baud_divisor_select ? 6'(PER_M2_FAST / OVERSAMPLE)
                   : 6'(PER_M2_SLOW / OVERSAMPLE);
      SMODE0:
        div = sm2 ? 6'(PER_M0_FAST / 2) : 6'(PER_M0_SLOW / 2);
    endcase
  end

  // Tick when the count wraps
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 6'h00;
      tick <= 1'b0;
    end
    else
    begin
      tick <= 1'b0;
      if (step)
      begin
        if (cnt >= div - 6'h01)
        begin
          cnt <= 6'h00;
          tick <= 1'b1;
        end
        else
          cnt <= cnt + 6'h01;
      end
    end
  end

endmodule

//--- hdl/ubmp_uart0.sv
// Serial port 0: data buffers, mode, phase and control registers,
// transmitter, receiver and PWM combine on the transmit pin.
// Assumes an APB master on pclk; rxd_in is asynchronous, the timer 2
// low waveform comes from logic on pclk.
//
// How it works
// - Data buffers clear to zero on reset
// - Write fills transmit, read returns receive
// - Mode register clears to zero on reset
// - Framing check off: bit 7 is mode
// - Framing check on: bit 7 is flag
// - Divisor bit one: 16 baud, 32 sys
// - Divisor bit zero: 64 baud, 64 sys
// - Interrupt enable gates receive/transmit flags
// - Mode register bits 5:3 read zero
// - PWM with select zero drives NOR
// - PWM with select one drives OR
// - PWM only in asynchronous modes
// - Mode 0 ignores PWM bits entirely
// - PWM off: select ignored, plain output
// - Phase register clears to zero on reset
// - Phase register sets baud clock rate
// - Transmit flag set after last data bit
// - Receive flag set when byte arrives

module ubmp_uart0 import ubmp_pkg::*; (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  // APB answer
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  output logic uart_tx_pin,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  // Timer 2 low waveform
  input wire logic timer2_low_waveform,
  // Interrupt request
  output logic serial_irq
);

  // ****************************************************
  // Declarations
  // ****************************************************
  ubmp_mode_t mode_reg;      // Mode register
  ubmp_ctrl_t ctrl;          // Control register, bit 7 holds mode bit
  logic fe;                  // Framing error flag
  logic [15:0] phase;        // Baud phase register
  logic [7:0] tx_buf;        // Transmit buffer
  logic [7:0] rx_buf;        // Receive buffer
  ubmp_smode_t smode;        // Decoded serial mode
  logic tick;                // Shared bit tick
  logic access;              // APB transfer completes
  logic wr;                  // Completing write
  logic hit_data, hit_mode, hit_phase, hit_ctrl;
  logic [31:0] rd_mux;       // Read data before register
  // Transmitter
  ubmp_state_t tx_state;
  logic [10:0] tx_sh;        // Frame shift, LSB out first
  logic [3:0] tx_left;       // Bits still to send
  logic [3:0] tx_cnt;        // Ticks within a bit
  logic tx_bit_end;          // Current bit completes
  logic ti_set;              // Hardware sets transmit flag
  // Receiver
  logic rxd_m, rxd_s, rxd_p; // Synchroniser and edge history
  ubmp_state_t rx_state;
  logic [8:0] rx_sh;         // Incoming bits, enter at top
  logic [3:0] rx_cnt;        // Ticks within a bit
  logic [3:0] rx_idx;        // Bit index within frame
  logic ri_set;              // Hardware sets receive flag
  logic fe_set;              // Hardware sets framing flag
  logic rb8_load;            // Ninth bit captured
  logic rb8_val;
  logic next_txd;            // Transmit pin before register

  // Address decode, word aligned
  function automatic logic ubmp_hit(input logic [7:0] addr,
                                    input logic [5:0] idx);
    return (addr[1:0] == 2'b00) && (addr[7:2] == idx);
  endfunction

  assign smode = ubmp_decode(ctrl.sm0, ctrl.sm1);
  assign hit_data = ubmp_hit(paddr, IDX_DATA);
  assign hit_mode = ubmp_hit(paddr, IDX_MODE);
  assign hit_phase = ubmp_hit(paddr, IDX_PHASE);
  assign hit_ctrl = ubmp_hit(paddr, IDX_CTRL);
  assign access = psel && penable && pready;
  assign wr = access && pwrite;

  // ****************************************************
  // Bit tick generator
  // ****************************************************
  ubmp_tick_gen u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .phase(phase),
    .smode(smode),
    .baud_divisor_select(mode_reg.baud_divisor_select),
    .sm2(ctrl.sm2),
    .tick(tick)
  );

  // ****************************************************
  // APB slave
  // ****************************************************
  // Read mux; reserved and unmapped read zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_data)
      rd_mux = {24'h00_0000, rx_buf};
    else if (hit_mode)
      rd_mux = {24'h00_0000, mode_reg.pwm_en, mode_reg.ofs, 3'b000,
                mode_reg.irq_en, mode_reg.baud_divisor_select, mode_reg.framing_check_enable};
    else if (hit_phase)
      rd_mux = {16'h0000, phase};
    else if (hit_ctrl)
      rd_mux = {24'h00_0000, mode_reg.framing_check_enable ? fe : ctrl.sm0,
                ctrl[6:0]};
  end

  // One wait state; data and error latched with ready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready)
      begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr <= !(hit_data || hit_mode || hit_phase || hit_ctrl);
      end
    end
  end

  // ****************************************************
  // Mode and phase registers
  // ****************************************************
  // Reserved bits never stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_reg <= ubmp_mode_t'(RST_MODE);
    else if (wr && hit_mode)
    begin
      mode_reg <= ubmp_mode_t'(pwdata[7:0]);
      mode_reg.rsvd <= 3'b000;
    end
  end

  // Phase register sets the baud accumulator step
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      phase <= RST_PHASE;
    else if (wr && hit_phase)
      phase <= pwdata[15:0];
  end

  // ****************************************************
  // Control register and flags
  // ****************************************************
  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= ubmp_ctrl_t'(RST_CTRL);
      fe <= 1'b0;
    end
    else
    begin
      if (wr && hit_ctrl)
      begin
        ctrl.sm1 <= pwdata[6];
        ctrl.sm2 <= pwdata[5];
        ctrl.ren <= pwdata[4];
        ctrl.tb8 <= pwdata[3];
        ctrl.rb8 <= pwdata[2];
        ctrl.ti <= pwdata[1];
        ctrl.ri <= pwdata[0];
        if (mode_reg.framing_check_enable)
          fe <= pwdata[7];
        else
          ctrl.sm0 <= pwdata[7];
      end
      if (rb8_load)
        ctrl.rb8 <= rb8_val;
      if (ti_set)
        ctrl.ti <= 1'b1;
      if (ri_set)
        ctrl.ri <= 1'b1;
      if (fe_set)
        fe <= 1'b1;
    end
  end

  // ****************************************************
  // Transmitter
  // ****************************************************
  // Mode 0 uses two ticks a bit, async sixteen
  assign tx_bit_end = (tx_state == ST_SYNC) ? tx_cnt[0]
                                             : (tx_cnt == 4'hF);
  // Flag after last data bit, i.e. before the stop bit when async
  assign ti_set = (tx_state != ST_IDLE) && tick && tx_bit_end &&
                  (tx_left == ((tx_state == ST_SYNC) ? 4'h1 : 4'h2));

  // Transmit buffer; a write during a frame restarts it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_buf <= RST_DATA;
      tx_state <= ST_IDLE;
      tx_sh <= 11'h7FF;
      tx_left <= 4'h0;
      tx_cnt <= 4'h0;
    end
    else if (wr && hit_data)
    begin
      tx_buf <= pwdata[7:0];
      tx_cnt <= 4'h0;
      unique case (smode)
        SMODE0:
        begin
          tx_state <= ST_SYNC;
          tx_sh <= {3'b111, pwdata[7:0]};
          tx_left <= SYNC_BITS;
        end
        SMODE1:
        begin
          tx_state <= ST_ASYNC;
          tx_sh <= {2'b11, pwdata[7:0], 1'b0};
          tx_left <= M1_BITS;
        end
        SMODE2, SMODE3:
        begin
          tx_state <= ST_ASYNC;
          tx_sh <= {1'b1, ctrl.tb8, pwdata[7:0], 1'b0};
          tx_left <= M23_BITS;
        end
      endcase
    end
    else if (tx_state != ST_IDLE && tick)
    begin
      tx_cnt <= tx_cnt + 4'h1;
      if (tx_bit_end)
      begin
        tx_cnt <= 4'h0;
        tx_sh <= {1'b1, tx_sh[10:1]};
        tx_left <= tx_left - 4'h1;
        if (tx_left == 4'h1)
          tx_state <= ST_IDLE;
      end
    end
  end

  // ****************************************************
  // Receiver
  // ****************************************************
  // Two-stage synchroniser, then an edge history stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rxd_m <= 1'b1;
      rxd_s <= 1'b1;
      rxd_p <= 1'b1;
    end
    else
    begin
      rxd_m <= rxd_in;
      rxd_s <= rxd_m;
      rxd_p <= rxd_s;
    end
  end

  // Receive engine; mode 0 samples at the end of each shift clock high phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_state <= ST_IDLE;
      rx_sh <= 9'h000;
      rx_cnt <= 4'h0;
      rx_idx <= 4'h0;
      rx_buf <= RST_DATA;
      ri_set <= 1'b0;
      fe_set <= 1'b0;
      rb8_load <= 1'b0;
      rb8_val <= 1'b0;
    end
    else
    begin
      ri_set <= 1'b0;
      fe_set <= 1'b0;
      rb8_load <= 1'b0;
      unique case (rx_state)
        ST_IDLE:
        begin
          rx_cnt <= 4'h0;
          rx_idx <= 4'h0;
          // Mode 0 reception starts on enable with flag clear
          if (smode == SMODE0 && ctrl.ren && !ctrl.ri &&
              tx_state == ST_IDLE)
            rx_state <= ST_SYNC;
          else if (smode != SMODE0 && ctrl.ren && rxd_p && !rxd_s)
            rx_state <= ST_ASYNC;
        end
        ST_SYNC:
          if (tick)
          begin
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt[0])
            begin
              rx_sh <= {rxd_s, rx_sh[8:1]};
              rx_idx <= rx_idx + 4'h1;
              if (rx_idx == SYNC_BITS - 4'h1)
              begin
                rx_buf <= {rxd_s, rx_sh[8:2]};
                ri_set <= 1'b1;
                rx_state <= ST_IDLE;
              end
            end
          end
        ST_ASYNC:
          if (tick)
          begin
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt == MID_SAMPLE)
            begin
              if (rx_idx == 4'h0)
              begin
                // A start bit that is high again was noise
                if (rxd_s)
                  rx_state <= ST_IDLE;
                else
                  rx_idx <= 4'h1;
              end
              else
              begin
                rx_sh <= {rxd_s, rx_sh[8:1]};
                rx_idx <= rx_idx + 4'h1;
                // Ninth bit: stop bit in mode 1, extra bit otherwise
                if (rx_idx == 4'h9 && !ctrl.ri &&
                    (!ctrl.sm2 || rxd_s))
                begin
                  rx_buf <= rx_sh[8:1];
                  rb8_load <= 1'b1;
                  rb8_val <= rxd_s;
                  ri_set <= 1'b1;
                end
                if (rx_idx == ((smode == SMODE1) ? M1_BITS : M23_BITS)
                    - 4'h1)
                begin
                  fe_set <= mode_reg.framing_check_enable && !rxd_s;
                  rx_state <= ST_IDLE;
                end
              end
            end
          end
        default:
          rx_state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************
  // Pin drive and interrupt
  // ****************************************************
  // Mode 0: tx pin is the shift clock, PWM bits have no say
  always_comb
  begin
    next_txd = 1'b1;
    if (smode == SMODE0)
    begin
      if (tx_state == ST_SYNC)
        next_txd = tx_cnt[0];
      else if (rx_state == ST_SYNC)
        next_txd = rx_cnt[0];
    end
    else
    begin
      next_txd = (tx_state == ST_ASYNC) ? tx_sh[0] : 1'b1;
      if (mode_reg.pwm_en)
        next_txd = mode_reg.ofs
          ? (next_txd | timer2_low_waveform)
          : !(next_txd | timer2_low_waveform);
    end
  end

  // Registered pins; the extra cycle keeps outputs glitch free
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      uart_tx_pin <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe <= 1'b0;
      serial_irq <= 1'b0;
    end
    else
    begin
      uart_tx_pin <= next_txd;
      rxd_out <= tx_sh[0];
      rxd_oe <= (tx_state == ST_SYNC);
      serial_irq <= mode_reg.irq_en && (ctrl.ri || ctrl.ti);
    end
  end

endmodule

//--- test/ubmp_props.sv
// Checker of the serial port 0 block, bound to its top module.
// Assumes APB requests are held until pready.
module ubmp_props import ubmp_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic uart_tx_pin,
  input wire logic rxd_oe,
  input wire logic timer2_low_waveform,
  input wire logic serial_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ***
  // Shadow of mode and mode bits
  // ***
  logic wr_done; // Completed write
  logic mapped; // Address hits a register
  logic [7:0] m_q; // Mode register copy
  logic [7:0] m_d; // Copy aligned with pin
  logic sm0_q; // Mode bit zero
  logic sm1_q; // Mode bit one
  logic async_d; // Async mode, aligned
  assign wr_done = psel & penable & pready & pwrite;
  assign mapped = paddr[1:0] == 2'h0 &&
    paddr[7:2] inside {IDX_DATA, IDX_MODE, IDX_PHASE, IDX_CTRL};
  // Bit 7 write is a flag write while framing check is on
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      m_q <= 8'h00;
      m_d <= 8'h00;
      sm0_q <= 1'b0;
      sm1_q <= 1'b0;
      async_d <= 1'b0;
    end
    else
    begin
      if (wr_done && paddr == {IDX_MODE, 2'h0})
        m_q <= pwdata[7:0];
      if (wr_done && paddr == {IDX_CTRL, 2'h0})
      begin
        sm1_q <= pwdata[6];
        if (!m_q[0])
          sm0_q <= pwdata[7];
      end
      m_d <= m_q;
      async_d <= sm0_q | sm1_q;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ONE_WAIT:
    assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  AST_PULSE:
    assert property (pready |=> !pready) else $error("pready held");
  AST_ERR_MAP:
    assert property (pready |-> pslverr == !mapped)
    else $error("pslverr wrong");
  AST_ERR_READ_ZERO:
    assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_MODE_RSVD:
    assert property (pready && !pwrite && paddr[7:2] == IDX_MODE
      |-> prdata[5:3] == 3'h0 && prdata[31:8] == 24'h0)
    else $error("reserved mode bits set");
  AST_IRQ_OFF:
    assert property (wr_done && paddr[7:2] == IDX_MODE && !pwdata[2]
      |-> ##2 !serial_irq) else $error("irq not gated");
  AST_NOR:
    assert property (m_d[7] && !m_d[6] && async_d && uart_tx_pin
      |-> !$past(timer2_low_waveform)) else $error("nor wrong");
  AST_OR:
    assert property (m_d[7] && m_d[6] && async_d && !uart_tx_pin
      |-> !$past(timer2_low_waveform)) else $error("or wrong");
  AST_RESET_IDLE:
    assert property ($rose(presetn)
      |-> uart_tx_pin && !rxd_oe && !serial_irq && !pready)
    else $error("outputs not idle after reset");
  AST_OE_SYNC:
    assert property (rxd_oe |-> !async_d) else $error("oe outside mode 0");
endmodule

bind ubmp_uart0 ubmp_props i_ubmp_props(.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .uart_tx_pin, .rxd_oe, .timer2_low_waveform, .serial_irq);

//--- test/ubmp_remote.sv
// Remote serial device facing the transmit and data pins.
// Assumes the bench sets the bit period in system clocks.
module ubmp_remote (
  // Clock
  input wire logic pclk,
  // Lines from the device
  input wire logic txd,
  input wire logic oe,
  input wire logic dq,
  input wire logic [15:0] bit_len,
  // Line towards the device
  output logic rxd,
  // Captured bytes
  output logic [7:0] rx_byte,
  output logic [7:0] m0_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rxd = 1'b1;
  initial rx_byte = 8'h00;
  initial m0_byte = 8'h00;
  // Async receiver, mid-bit sampling; no resync on glitches
  always
  begin
    @(negedge txd);
    if (!oe)
    begin
      repeat (bit_len / 2) @(posedge pclk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (bit_len) @(posedge pclk);
        rx_byte[i] = txd;
      end
    end
  end
  // Sync capture on the rising shift clock, LSB first
  always @(posedge txd)
    if (oe)
      m0_byte <= {dq, m0_byte[7:1]};
  // Start, eight data bits LSB first, chosen stop level
  task send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxd <= f[i];
      repeat (bit_len) @(posedge pclk);
    end
    rxd <= 1'b1;
  endtask
endmodule

//--- test/testbench.sv
// Self-checking bench of the serial port 0 block.
// Assumes the checker is bound and the remote model drives rxd.
module testbench import ubmp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic timer2_low_waveform = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, uart_tx_pin, rxd_in, rxd_out, rxd_oe;
  logic serial_irq, rem_rxd, ev, x;
  logic [15:0] bit_len = 16'h0020;
  logic [7:0] rx_byte, m0_byte, b;
  logic [31:0] rv, v;
  int n_errors = 0;
  int comparisons = 0;
  // Transfer table: control, mode, bit period
  localparam logic [7:0] CT[5] = '{8'h58, 8'h58, 8'h98, 8'h98, 8'hD8};
  localparam logic [7:0] MD[5] = '{8'h02, 8'h00, 8'h02, 8'h00, 8'h02};
  localparam logic [15:0] BL[5] = '{32, 128, 32, 64, 32};
  always #5 pclk = ~pclk;
  // Data pin is shared in mode 0
  assign rxd_in = rxd_oe ? rxd_out : rem_rxd;
  always @(posedge pclk) timer2_low_waveform <= 1'($urandom);
  ubmp_uart0 i_ubmp_uart0(.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .uart_tx_pin,
    .rxd_in, .rxd_out, .rxd_oe, .timer2_low_waveform, .serial_irq);
  ubmp_remote i_ubmp_remote(.pclk, .txd(uart_tx_pin), .oe(rxd_oe),
    .dq(rxd_out), .bit_len, .rxd(rem_rxd), .rx_byte, .m0_byte);
  // ***
  // Bus and compare tasks
  // ***
  task apb(input logic w, input logic [5:0] ix, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task chk32(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h, want %h", $time, g, e);
    end
  endtask
  task chk1(input logic g, input logic e);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch at %0t: bit %b, want %b", $time, g, e);
    end
  endtask
  task rdc(input logic [5:0] ix, input logic [31:0] e);
    apb(1'b0, ix, 32'h0);
    chk32(rv, e);
  endtask
  // Polls control until a flag shows, bounded
  task wait_flag(input logic [7:0] m);
    for (int i = 0; i < 1000; i++)
    begin
      apb(1'b0, IDX_CTRL, 32'h0);
      if ((rv[7:0] & m) != 8'h00)
        break;
    end
    chk1((rv[7:0] & m) != 8'h00, 1'b1);
  endtask
  task end_of_test;
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Watchdog, well above the expected run
  initial
  begin
    #400000;
    n_errors++;
    end_of_test();
  end
  initial
  begin
    void'($urandom(32'h3D5B));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(IDX_DATA, 32'h0);
    rdc(IDX_MODE, 32'h0);
    rdc(IDX_PHASE, 32'h0);
    $display("test reset finished");
    for (int i = 0; i < 4; i++)
    begin
      v = $urandom;
      apb(1'b1, IDX_MODE, {24'h0, v[7:0]});
      rdc(IDX_MODE, v & 32'hC7);
      apb(1'b1, IDX_PHASE, v >> 16);
      rdc(IDX_PHASE, v >> 16);
    end
    apb(1'b1, 6'h0F, v);
    chk1(ev, 1'b1);
    rdc(6'h0F, 32'h0);
    $display("test registers finished");
    // Baud clock every second system clock
    apb(1'b1, IDX_PHASE, 32'h8000);
    for (int k = 0; k < 5; k++)
    begin
      // Mode first: a stale PWM bit must not toggle the pin
      apb(1'b1, IDX_MODE, MD[k]);
      apb(1'b1, IDX_CTRL, CT[k]);
      bit_len <= BL[k];
      b = 8'($urandom);
      apb(1'b1, IDX_DATA, b);
      wait_flag(8'h02);
      chk32(rx_byte, b);
      repeat (3 * BL[k]) @(posedge pclk);
    end
    $display("test transmit finished");
    apb(1'b1, IDX_CTRL, 8'h50);
    apb(1'b1, IDX_MODE, 8'h06);
    bit_len <= 16'h0020;
    b = 8'($urandom);
    i_ubmp_remote.send(b, 1'b1);
    wait_flag(8'h01);
    rdc(IDX_DATA, b);
    chk1(serial_irq, 1'b1);
    apb(1'b1, IDX_MODE, 8'h02);
    repeat (2) @(posedge pclk);
    chk1(serial_irq, 1'b0);
    apb(1'b1, IDX_CTRL, 8'h50);
    apb(1'b1, IDX_MODE, 8'h03);
    i_ubmp_remote.send(b, 1'b0);
    wait_flag(8'h80);
    $display("test receive finished");
    // Zero byte keeps the serial output low, exposing the timer wave;
    // the last pass has PWM off with the OR select set
    for (int o = 0; o < 3; o++)
    begin
      apb(1'b1, IDX_CTRL, 8'h50);
      apb(1'b1, IDX_MODE, {o < 2, o != 0, 6'h02});
      apb(1'b1, IDX_DATA, 32'h0);
      repeat (8) @(posedge pclk);
      for (int i = 0; i < 100; i++)
      begin
        x = (o < 2) & ((o == 1) ~^ timer2_low_waveform);
        @(posedge pclk);
        chk1(uart_tx_pin, x);
      end
      wait_flag(8'h02);
    end
    apb(1'b1, IDX_MODE, 8'h42);
    repeat (20) @(posedge pclk)
      chk1(uart_tx_pin, 1'b1);
    $display("test pwm finished");
    // Mode 0 with framing check on: bit 7 write must not leave mode 0
    apb(1'b1, IDX_CTRL, 8'h00);
    apb(1'b1, IDX_MODE, 8'h81);
    apb(1'b1, IDX_CTRL, 8'h80);
    b = 8'($urandom);
    apb(1'b1, IDX_DATA, b);
    wait_flag(8'h02);
    chk32(m0_byte, b);
    chk1(uart_tx_pin, 1'b1);
    $display("test sync finished");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(IDX_MODE, 32'h0);
    rdc(IDX_PHASE, 32'h0);
    rdc(IDX_DATA, 32'h0);
    $display("test second reset finished");
    end_of_test();
  end
endmodule
